// *** common/oag_pkg.sv ***
package oag_pkg;

    // address map figures
    localparam logic [7:0] SPECIAL_BASE    = 8'h80;   // direct: at or above is special register
    localparam logic [7:0] BIT_BYTE_BASE   = 8'h20;   // first bit-addressable data byte
    localparam logic [2:0] BIT_SPECIAL_LOW = 3'h0;    // special register low nibble ends 0h or 8h
    localparam logic [7:0] RESET_BYTE      = 8'h00;
    localparam logic [15:0] RESET_WORD     = 16'h0000;
    localparam int         NUM_POINTERS    = 2;

    // addressing modes presented by the decoder
    typedef enum logic [3:0] {
        MODE_REGISTER,
        MODE_DIRECT,
        MODE_REG_INDIRECT,
        MODE_IMMEDIATE,
        MODE_IMMEDIATE16,
        MODE_EXT_DIRECT,
        MODE_EXT_INDIRECT,
        MODE_INDEXED,
        MODE_RELATIVE,
        MODE_ABSOLUTE,
        MODE_LONG,
        MODE_BIT
    } addr_mode_t;

    // memory space selected by an operand address
    typedef enum logic [2:0] {
        SPACE_NONE,
        SPACE_DATA_RAM,
        SPACE_UPPER_RAM,
        SPACE_SPECIAL,
        SPACE_EXTERNAL,
        SPACE_CODE
    } space_t;

    // one decoded instruction handed in by the decoder
    typedef struct packed {
        addr_mode_t  mode;
        logic [7:0]  opcode;
        logic [7:0]  byte2;
        logic [7:0]  byte3;
        logic        ext_write;   // external move direction: 1 = accumulator to external
        logic        use_pc;      // indexed read relative to program counter
        logic        bit_value;   // value written by a bit operation
        logic        ptr_swap;    // alternate the active data pointer after this access
    } instr_t;

    // core state that the generator reads
    typedef struct packed {
        logic [15:0] pc_next;     // address of the following instruction
        logic [7:0]  acc;
        logic [7:0]  r0;
        logic [7:0]  r1;
    } core_view_t;

    // one memory request
    typedef struct packed {
        space_t      space;
        logic [15:0] addr;
        logic        write;
        logic [7:0]  wdata;
        logic        bit_op;
        logic [2:0]  bit_index;
        logic        bit_value;
    } mem_req_t;

endpackage

// *** core/bit_locator.sv ***
`timescale 1ns/1ps
module bit_locator
    import oag_pkg::*;
(
    input  wire logic [7:0] bit_addr,
    output logic [7:0]      byte_addr,
    output logic [2:0]      bit_index,
    output space_t          space
);
    // split a bit address into its byte and the bit within it
    always_comb begin
        bit_index = bit_addr[2:0];
        if (bit_addr < SPECIAL_BASE) begin
            byte_addr = BIT_BYTE_BASE + {4'h0, bit_addr[6:3]};
            space     = SPACE_DATA_RAM;
        end else begin
            byte_addr = {bit_addr[7:3], BIT_SPECIAL_LOW};
            space     = SPACE_SPECIAL;
        end
    end
endmodule // bit_locator

// *** core/operand_address_generator.sv ***
`timescale 1ns/1ps
// How it works
// - register mode picks r0..r7 from the low three opcode bits.
// - direct byte below 80h hits data ram, otherwise special registers.
// - indirect through r0 or r1 reaches upper ram only, never special registers.
// - immediate byte from the second instruction byte goes to its destination.
// - sixteen-bit immediate loads the data pointer from bytes two and three.
// - external move transfers one byte to or from accumulator at data pointer.
// - two data pointers can be alternated for fast memory-to-memory copies.
// - external indirect mode is unsupported; flagged and no access made.
// - code read addresses accumulator plus pc or pointer; result overwrites accumulator.
// - relative mode adds the signed second byte to the program counter.
// - absolute target joins top five pc bits with eleven instruction bits.
// - long call and jump use the sixteen-bit address after the opcode.
// - bit operations change one bit only, in 20h-2Fh or x0h/x8h registers.
// - special register bit address is byte address plus bit index.
module operand_address_generator
    import oag_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        instr_valid,
    input  oag_pkg::instr_t  instr,
    input  oag_pkg::core_view_t core,
    output oag_pkg::mem_req_t req,
    output logic             req_valid,
    output logic [2:0]       reg_select,
    output logic             reg_select_valid,
    output logic [15:0]      jump_target,
    output logic             jump_valid,
    output logic             acc_load,
    output logic [15:0]      data_pointer,
    output logic             active_pointer,
    output logic             unsupported
);
    import oag_pkg::*;

    typedef struct packed {
        mem_req_t    req;
        logic        req_valid;
        logic [2:0]  reg_sel;
        logic        reg_sel_valid;
        logic [15:0] jump;
        logic        jump_valid;
        logic        acc_load;
        logic [15:0] dp0;
        logic [15:0] dp1;
        logic        dp_sel;
        logic        unsupported;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic [7:0] bit_byte;
    logic [2:0] bit_idx;
    space_t     bit_space;
    logic [15:0] dp_cur;

    bit_locator u_bit_locator (
        .bit_addr  (instr.byte2),
        .byte_addr (bit_byte),
        .bit_index (bit_idx),
        .space     (bit_space)
    );

    assign dp_cur = s_q.dp_sel ? s_q.dp1 : s_q.dp0;

    // decode one instruction per valid cycle; requests and valid pulses stand one cycle, reg_sel and jump hold
    always_comb begin
        s_d               = s_q;
        s_d.req           = '0;
        s_d.req_valid     = 1'b0;
        s_d.reg_sel_valid = 1'b0;
        s_d.jump_valid    = 1'b0;
        s_d.acc_load      = 1'b0;
        s_d.unsupported   = 1'b0;
        if (instr_valid) begin
            unique case (instr.mode)
                MODE_REGISTER: begin
                    s_d.reg_sel       = instr.opcode[2:0];
                    s_d.reg_sel_valid = 1'b1;
                end
                MODE_DIRECT: begin
                    s_d.req.space = (instr.byte2 < SPECIAL_BASE) ?
                                    SPACE_DATA_RAM : SPACE_SPECIAL;
                    s_d.req.addr  = {8'h00, instr.byte2};
                    s_d.req_valid = 1'b1;
                end
                MODE_REG_INDIRECT: begin
                    // special registers share these addresses but are never chosen here
                    s_d.req.space = SPACE_UPPER_RAM;
                    s_d.req.addr  = {8'h00, instr.opcode[0] ? core.r1 : core.r0};
                    s_d.req_valid = 1'b1;
                end
                MODE_IMMEDIATE: begin
                    s_d.req.space = (instr.byte3 < SPECIAL_BASE) ?
                                    SPACE_DATA_RAM : SPACE_SPECIAL;
                    s_d.req.addr  = {8'h00, instr.byte3};
                    s_d.req.write = 1'b1;
                    s_d.req.wdata = instr.byte2;
                    s_d.req_valid = 1'b1;
                end
                MODE_IMMEDIATE16: begin
                    if (s_q.dp_sel) begin
                        s_d.dp1 = {instr.byte2, instr.byte3};
                    end else begin
                        s_d.dp0 = {instr.byte2, instr.byte3};
                    end
                end
                MODE_EXT_DIRECT: begin
                    s_d.req.space = SPACE_EXTERNAL;
                    s_d.req.addr  = dp_cur;
                    s_d.req.write = instr.ext_write;
                    s_d.req.wdata = core.acc;
                    s_d.req_valid = 1'b1;
                    s_d.acc_load  = ~instr.ext_write;
                    if (instr.ptr_swap) begin
                        s_d.dp_sel = ~s_q.dp_sel;
                    end
                end
                MODE_EXT_INDIRECT: begin
                    s_d.unsupported = 1'b1;
                end
                MODE_INDEXED: begin
                    s_d.req.space = SPACE_CODE;
                    s_d.req.addr  = (instr.use_pc ? core.pc_next : dp_cur)
                                    + {8'h00, core.acc};
                    s_d.req_valid = 1'b1;
                    s_d.acc_load  = 1'b1;
                end
                MODE_RELATIVE: begin
                    s_d.jump = core.pc_next
                             + {{8{instr.byte2[7]}}, instr.byte2};
                    s_d.jump_valid = 1'b1;
                end
                MODE_ABSOLUTE: begin
                    s_d.jump = {core.pc_next[15:11], instr.opcode[7:5],
                                instr.byte2};
                    s_d.jump_valid = 1'b1;
                end
                MODE_LONG: begin
                    s_d.jump       = {instr.byte2, instr.byte3};
                    s_d.jump_valid = 1'b1;
                end
                MODE_BIT: begin
                    // read-modify-write of one bit keeps its neighbours intact
                    s_d.req.space     = bit_space;
                    s_d.req.addr      = {8'h00, bit_byte};
                    s_d.req.write     = 1'b1;
                    s_d.req.bit_op    = 1'b1;
                    s_d.req.bit_index = bit_idx;
                    s_d.req.bit_value = instr.bit_value;
                    s_d.req_valid     = 1'b1;
                end
                default: begin
                    s_d.unsupported = 1'b1;
                end
            endcase
        end
    end

    // single state register
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign req              = s_q.req;
    assign req_valid        = s_q.req_valid;
    assign reg_select       = s_q.reg_sel;
    assign reg_select_valid = s_q.reg_sel_valid;
    assign jump_target      = s_q.jump;
    assign jump_valid       = s_q.jump_valid;
    assign acc_load         = s_q.acc_load;
    assign data_pointer     = dp_cur;
    assign active_pointer   = s_q.dp_sel;
    assign unsupported      = s_q.unsupported;

    chk_register_select: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_REGISTER |=>
        reg_select_valid && reg_select == $past(instr.opcode[2:0]))
        else $error("register select wrong");

    chk_direct_space: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_DIRECT && instr.byte2[7] |=>
        req_valid && req.space == SPACE_SPECIAL)
        else $error("direct high byte not special");

    chk_indirect_space: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_REG_INDIRECT |=>
        req.space == SPACE_UPPER_RAM)
        else $error("indirect reached wrong space");

    chk_ext_address: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_EXT_DIRECT |=>
        req.space == SPACE_EXTERNAL && req.addr == $past(data_pointer))
        else $error("external address not data pointer");

    chk_ext_indirect: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_EXT_INDIRECT |=> unsupported && !req_valid)
        else $error("external indirect not refused");

    chk_indexed_sum: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_INDEXED && instr.use_pc |=>
        req.addr == $past(core.pc_next) + {8'h00, $past(core.acc)} && acc_load)
        else $error("indexed address wrong");

    chk_page_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_ABSOLUTE |=>
        jump_target[15:11] == $past(core.pc_next[15:11]))
        else $error("absolute jump left page");

    chk_long_target: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_LONG |=>
        jump_valid && jump_target == {$past(instr.byte2), $past(instr.byte3)})
        else $error("long target wrong");

    chk_pointer_swap: assert property (@(posedge sys_clk) disable iff (!nrst)
        instr_valid && instr.mode == MODE_EXT_DIRECT && instr.ptr_swap |=>
        active_pointer != $past(active_pointer))
        else $error("pointer did not alternate");
endmodule // operand_address_generator

// *** tb/oag_mem_model.sv ***
`timescale 1ns/1ps
// far side: external data space only, passive store of external writes
module oag_mem_model
    import oag_pkg::*;
(
    input  wire logic          sys_clk,
    input  oag_pkg::mem_req_t  req,
    input  wire logic          req_valid,
    input  wire logic [15:0]   peek_addr,
    output logic [7:0]         peek_data
);
    logic [7:0] ext_mem [0:65535];
    bit         ext_set [0:65535];   // two-state, so every place starts unwritten

    // store external writes so the bench can read back what really landed
    always @(posedge sys_clk) begin
        if (req_valid && req.space == SPACE_EXTERNAL && req.write) begin
            ext_mem[req.addr] <= req.wdata; // one byte per access
            ext_set[req.addr] <= 1'b1;
        end
    end

    // unwritten places read as a changing pattern, not as a stale byte
    always_comb begin
        peek_data = ext_set[peek_addr] ? ext_mem[peek_addr] : ~peek_addr[7:0];
    end
endmodule // oag_mem_model

// *** tb/test_operand_address_generator.sv ***
`timescale 1ns/1ps
module test_operand_address_generator;
    import oag_pkg::*;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        instr_valid = 1'b0;
    instr_t      instr = '0;
    core_view_t  core = '0;
    mem_req_t    req;
    logic        req_valid, reg_select_valid, jump_valid, acc_load, active_pointer, unsupported;
    logic [2:0]  reg_select;
    logic [15:0] jump_target, data_pointer;
    logic [15:0] peek_addr = 16'h0000;
    logic [7:0]  peek_data;
    int          err_total = 0;
    int          n_tests = 0;

    // 50 ns period
    always #25 sys_clk = ~sys_clk;

    operand_address_generator u_operand_address_generator (.sys_clk(sys_clk), .nrst(nrst),
        .instr_valid(instr_valid), .instr(instr), .core(core), .req(req), .req_valid(req_valid),
        .reg_select(reg_select), .reg_select_valid(reg_select_valid),
        .jump_target(jump_target), .jump_valid(jump_valid), .acc_load(acc_load),
        .data_pointer(data_pointer), .active_pointer(active_pointer),
        .unsupported(unsupported));
    oag_mem_model u_oag_mem_model (.sys_clk(sys_clk), .req(req), .req_valid(req_valid),
        .peek_addr(peek_addr), .peek_data(peek_data));

    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask

    // one instruction; answer is sampled at the next falling edge, where pulses stand
    task automatic go(input addr_mode_t m, input logic [7:0] op, b2, b3, input logic [3:0] f);
        @(negedge sys_clk);
        instr <= '{mode: m, opcode: op, byte2: b2, byte3: b3, ext_write: f[3], use_pc: f[2],
                   bit_value: f[1], ptr_swap: f[0]};
        instr_valid <= 1'b1;
        @(negedge sys_clk);
        instr_valid <= 1'b0;
    endtask

    task automatic chk_req(input space_t sp, input logic [15:0] a, input logic wr);
        cmp_bit(req_valid, 1'b1);
        cmp({13'h0000, req.space}, {13'h0000, sp});
        cmp(req.addr, a);
        cmp_bit(req.write, wr);
    endtask

    task automatic t_register_direct();
        go(MODE_REGISTER, 8'hed, 8'h00, 8'h00, 4'h0);
        cmp({13'h0000, reg_select}, 16'h0005);
        cmp_bit(reg_select_valid, 1'b1);
        go(MODE_DIRECT, 8'he5, 8'h7f, 8'h00, 4'h0);
        chk_req(SPACE_DATA_RAM, 16'h007f, 1'b0);
        go(MODE_DIRECT, 8'he5, 8'h80, 8'h00, 4'h0);
        chk_req(SPACE_SPECIAL, 16'h0080, 1'b0);
    endtask

    task automatic t_indirect_immediate();
        core.r0 <= 8'hff;
        core.r1 <= 8'h80;
        go(MODE_REG_INDIRECT, 8'he7, 8'h00, 8'h00, 4'h0);
        chk_req(SPACE_UPPER_RAM, 16'h0080, 1'b0);
        go(MODE_REG_INDIRECT, 8'he6, 8'h00, 8'h00, 4'h0);
        chk_req(SPACE_UPPER_RAM, 16'h00ff, 1'b0);
        go(MODE_IMMEDIATE, 8'h75, 8'h5a, 8'h90, 4'h0);
        chk_req(SPACE_SPECIAL, 16'h0090, 1'b1);
        cmp({8'h00, req.wdata}, 16'h005a);
    endtask

    // load pointer 0, write out through it and swap, load and read through pointer 1, then peek the written byte
    task automatic t_external();
        core.acc <= 8'h3c;
        go(MODE_IMMEDIATE16, 8'h90, 8'h12, 8'h34, 4'h0);
        cmp(data_pointer, 16'h1234);
        go(MODE_EXT_DIRECT, 8'hf0, 8'h00, 8'h00, 4'b1001);
        chk_req(SPACE_EXTERNAL, 16'h1234, 1'b1);
        cmp({8'h00, req.wdata}, 16'h003c);
        cmp_bit(active_pointer, 1'b1);
        cmp(data_pointer, 16'h0000);
        go(MODE_IMMEDIATE16, 8'h90, 8'hab, 8'hcd, 4'h0);
        go(MODE_EXT_DIRECT, 8'he0, 8'h00, 8'h00, 4'b0001);
        chk_req(SPACE_EXTERNAL, 16'habcd, 1'b0);
        cmp_bit(acc_load, 1'b1);
        cmp(data_pointer, 16'h1234);
        peek_addr <= 16'h1234;
        @(negedge sys_clk);
        cmp({8'h00, peek_data}, 16'h003c);
        go(MODE_EXT_INDIRECT, 8'hf2, 8'h00, 8'h00, 4'b1000);
        cmp_bit(unsupported, 1'b1);
        cmp_bit(req_valid, 1'b0);
    endtask

    task automatic t_code_jumps();
        core.acc <= 8'hff;
        core.pc_next <= 16'h10f0;
        go(MODE_INDEXED, 8'h83, 8'h00, 8'h00, 4'b0100);
        chk_req(SPACE_CODE, 16'h11ef, 1'b0);
        cmp_bit(acc_load, 1'b1);
        go(MODE_INDEXED, 8'h93, 8'h00, 8'h00, 4'h0);
        chk_req(SPACE_CODE, 16'h1333, 1'b0);
        core.pc_next <= 16'h1002;
        go(MODE_RELATIVE, 8'h80, 8'h32, 8'h00, 4'h0);
        cmp(jump_target, 16'h1034);
        go(MODE_RELATIVE, 8'h80, 8'h80, 8'h00, 4'h0);
        cmp(jump_target, 16'h0f82);
        core.pc_next <= 16'h47fe;
        go(MODE_ABSOLUTE, 8'he1, 8'hff, 8'h00, 4'h0);
        cmp(jump_target, 16'h47ff);
        go(MODE_LONG, 8'h02, 8'h05, 8'h00, 4'h0);
        cmp(jump_target, 16'h0500);
        cmp_bit(jump_valid, 1'b1);
    endtask

    task automatic t_bits();
        go(MODE_BIT, 8'hd2, 8'haf, 8'h00, 4'b0010);
        chk_req(SPACE_SPECIAL, 16'h00a8, 1'b1);
        cmp({13'h0000, req.bit_index}, 16'h0007);
        cmp_bit(req.bit_op, 1'b1);
        cmp_bit(req.bit_value, 1'b1);
        go(MODE_BIT, 8'hc2, 8'h7f, 8'h00, 4'h0);
        chk_req(SPACE_DATA_RAM, 16'h002f, 1'b1);
        cmp_bit(req.bit_value, 1'b0);
        go(MODE_BIT, 8'hc2, 8'h00, 8'h00, 4'h0);
        cmp(req.addr, 16'h0020);
    endtask

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // the tests need well under 200 cycles; 4000 leaves ample margin
    initial begin
        #200us;
        err_total++;
        stop_test();
    end

    initial begin
        repeat (12) @(negedge sys_clk);
        nrst <= 1'b1;
        cmp(data_pointer, RESET_WORD);
        t_register_direct();
        t_indirect_immediate();
        t_external();
        t_code_jumps();
        t_bits();
        stop_test();
    end
endmodule // test_operand_address_generator
